// *** logic/temp_fault_response.sv ***
// temperature fault response: action bytes, sticky status, alert and cml flags
// assumes a byte command port decoded by the serial front end, synchronous inputs
//
// Behaviour
// - internal overtemperature action byte is unpaged, read-only, value 0xc0.
// - internal overtemperature sets manufacturer summary and its status bit, raises alert.
// - every response code still sets the status bit and raises alert.
// - writing internal response code 00 or 01 raises a cml fault.
// - response 10 disables the output at once, then restarts only for retry 111, else stays off.
// - response 11 keeps output off only while the fault lasts.
// - status bits clear only by clear faults, off-then-on, or bias loss.
// - internal retry is fixed at 000; writing 001-111 raises cml fault.
// - delay field of the internal action byte is ignored.
// - paged read/write external overtemperature action byte, reset 0xb8.
// - paged read/write external undertemperature action byte, reset 0xb8.
// - external overtemperature sets temperature summary and its bit, raises alert.
// - external faults are reacted to within 90 ms, at adc sampling.
// - external undertemperature sets temperature summary and its bit, raises alert.
// - external response 00 keeps running while still flagging the fault.
// - external retry 111 restarts endlessly each retry interval until stopped.
`timescale 1ns/1ps
module temp_fault_response
  import temp_fault_pkg::*;
#(
  parameter int NUM_CH = CH_COUNT,
  parameter int RESP_LIMIT = RESP_LIMIT_CYCLES
)(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic cmd_write_i,
  input wire logic cmd_read_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic cmd_page_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic int_ot_i,
  input wire logic [NUM_CH-1:0] ext_ot_i,
  input wire logic [NUM_CH-1:0] ext_ut_i,
  input wire logic adc_update_i,
  input wire logic [NUM_CH-1:0] channel_run_pin_i,
  input wire logic [NUM_CH-1:0] operation_on_i,
  input wire logic [NUM_CH-1:0] retry_due_i,
  output logic [7:0] read_data_o,
  output logic read_valid_o,
  output logic cml_fault_o,
  output fault_status_t status_o,
  output logic alert_o,
  output logic [NUM_CH-1:0] output_en_o,
  output logic [NUM_CH-1:0] retry_req_o
);

  // elaboration checks: page select is one bit, status holds two channels
  if (NUM_CH != CH_COUNT) begin : g_bad_ch
    $error("NUM_CH must equal CH_COUNT");
  end
  if (RESP_LIMIT < 1) begin : g_bad_limit
    $error("RESP_LIMIT must be at least one cycle");
  end

  localparam action_t INT_ACTION = action_t'(INT_ACTION_VALUE);

  action_t ot_action_reg [NUM_CH], ot_action_next [NUM_CH];
  action_t ut_action_reg [NUM_CH], ut_action_next [NUM_CH];
  logic [NUM_CH-1:0] ext_ot_seen_reg, ext_ot_seen_next;
  logic [NUM_CH-1:0] ext_ut_seen_reg, ext_ut_seen_next;
  logic [31:0] sample_cnt_reg, sample_cnt_next;
  logic [NUM_CH-1:0] run_prev_reg, run_prev_next;
  fault_status_t status_reg, status_next;
  logic cml_reg, cml_next, alert_reg, alert_next;
  logic [7:0] rd_data_reg, rd_data_next;
  logic rd_valid_reg, rd_valid_next;
  logic sample, clear_all;
  logic [NUM_CH-1:0] run_now, run_rise;
  action_t wr_action;

  // command decode, action byte writes and cml detection
  always_comb begin
    wr_action = action_t'(cmd_data_i);
    clear_all = cmd_write_i && (cmd_code_i == CMD_CLEAR_FAULTS);
    ot_action_next = ot_action_reg;
    ut_action_next = ut_action_reg;
    cml_next = cml_reg && !clear_all;
    if (cmd_write_i) begin
      case (cmd_code_i)
        CMD_INT_OT: begin
          // byte is fixed; unsupported response or retry codes flag cml
          if (wr_action.resp == RESP_CONTINUE || wr_action.resp == RESP_UNSUP ||
              wr_action.retry != RETRY_NONE) begin
            cml_next = 1'b1;
          end
        end
        CMD_EXT_OT: begin
          if (wr_action.resp == RESP_UNSUP || wr_action.resp == RESP_WHILE) begin
            cml_next = 1'b1;
          end else begin
            ot_action_next[cmd_page_i] = wr_action;
          end
        end
        CMD_EXT_UT: begin
          if (wr_action.resp == RESP_UNSUP || wr_action.resp == RESP_WHILE) begin
            cml_next = 1'b1;
          end else begin
            ut_action_next[cmd_page_i] = wr_action;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // read path, one cycle after the request
  always_comb begin
    rd_valid_next = cmd_read_i;
    rd_data_next = READ_NONE;
    if (cmd_read_i) begin
      case (cmd_code_i)
        CMD_INT_OT: rd_data_next = INT_ACTION;
        CMD_EXT_OT: rd_data_next = ot_action_reg[cmd_page_i];
        CMD_EXT_UT: rd_data_next = ut_action_reg[cmd_page_i];
        default: rd_data_next = READ_NONE;
      endcase
    end
  end

  // external faults are taken at each adc update, or at the latest each limit
  always_comb begin
    sample = adc_update_i || (sample_cnt_reg == 32'(RESP_LIMIT - 1));
    sample_cnt_next = sample ? 32'h0 : sample_cnt_reg + 32'h1;
    ext_ot_seen_next = sample ? ext_ot_i : ext_ot_seen_reg;
    ext_ut_seen_next = sample ? ext_ut_i : ext_ut_seen_reg;
    run_now = channel_run_pin_i & operation_on_i;
    run_prev_next = run_now;
    run_rise = run_now & ~run_prev_reg;
  end

  // sticky status: set wins over clear
  always_comb begin
    status_next = status_reg;
    status_next.int_ot = (status_reg.int_ot && !(clear_all || (|run_rise))) ||
                         int_ot_i;
    for (int c = 0; c < NUM_CH; c++) begin
      status_next.ext_ot[c] = (status_reg.ext_ot[c] && !(clear_all || run_rise[c])) ||
                              ext_ot_seen_reg[c];
      status_next.ext_ut[c] = (status_reg.ext_ut[c] && !(clear_all || run_rise[c])) ||
                              ext_ut_seen_reg[c];
    end
    status_next.mfr_summary = status_next.int_ot;
    status_next.temp_summary = (|status_next.ext_ot) || (|status_next.ext_ut);
    // alert for any flagged fault, regardless of response code
    alert_next = status_next.mfr_summary || status_next.temp_summary || cml_next;
  end

  // registers
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        ot_action_reg[c] <= action_t'(EXT_ACTION_RESET);
        ut_action_reg[c] <= action_t'(EXT_ACTION_RESET);
      end
      ext_ot_seen_reg <= '0;
      ext_ut_seen_reg <= '0;
      sample_cnt_reg <= 32'h0;
      run_prev_reg <= '0;
      status_reg <= '0;
      cml_reg <= 1'b0;
      alert_reg <= 1'b0;
      rd_data_reg <= READ_NONE;
      rd_valid_reg <= 1'b0;
    end else begin
      ot_action_reg <= ot_action_next;
      ut_action_reg <= ut_action_next;
      ext_ot_seen_reg <= ext_ot_seen_next;
      ext_ut_seen_reg <= ext_ut_seen_next;
      sample_cnt_reg <= sample_cnt_next;
      run_prev_reg <= run_prev_next;
      status_reg <= status_next;
      cml_reg <= cml_next;
      alert_reg <= alert_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  // one controller per channel; internal fault feeds every channel
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    ch_fault_t ch_faults;
    assign ch_faults = '{int_ot: int_ot_i, ext_ot: ext_ot_seen_reg[c],
                         ext_ut: ext_ut_seen_reg[c]};
    channel_fault_ctrl u_ctrl (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .run_cmd_i(run_now[c]),
      .faults_i(ch_faults),
      .int_action_i(INT_ACTION),
      .ot_action_i(ot_action_reg[c]),
      .ut_action_i(ut_action_reg[c]),
      .retry_due_i(retry_due_i[c]),
      .output_en_o(output_en_o[c]),
      .retry_req_o(retry_req_o[c])
    );
  end

  assign read_data_o = rd_data_reg;
  assign read_valid_o = rd_valid_reg;
  assign cml_fault_o = cml_reg;
  assign status_o = status_reg;
  assign alert_o = alert_reg;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  // both channels running with no external fault, internal fault comes and goes
  sequence int_fault_then_quiet;
    (output_en_o == '1) && int_ot_i && (&run_now) && ext_ot_seen_reg == '0 &&
      ext_ut_seen_reg == '0
    ##1 (!int_ot_i && (&run_now) && ext_ot_seen_reg == '0 && ext_ut_seen_reg == '0) [*2];
  endsequence

  int_action_read_a: assert property (
    cmd_read_i && cmd_code_i == CMD_INT_OT |=> read_valid_o && read_data_o == INT_ACTION_VALUE)
    else $error("internal action byte did not read back as fixed value");

  int_status_alert_a: assert property (
    int_ot_i |=> status_o.int_ot && status_o.mfr_summary && alert_o)
    else $error("internal fault not flagged with alert");

  int_bad_write_a: assert property (
    cmd_write_i && cmd_code_i == CMD_INT_OT && !cmd_data_i[7] |=> cml_fault_o)
    else $error("unsupported internal response write without cml");

  int_shutdown_both_a: assert property (
    int_ot_i |=> output_en_o == '0)
    else $error("internal fault left a channel enabled");

  int_resume_a: assert property (
    int_fault_then_quiet |-> output_en_o == '1)
    else $error("output stayed off after internal fault went away");

  ext_status_sticky_a: assert property (
    status_o.ext_ot[0] && !clear_all && !run_rise[0] |=> status_o.ext_ot[0])
    else $error("external status bit cleared without a clearing event");

  ext_bad_write_a: assert property (
    cmd_write_i && cmd_code_i == CMD_EXT_OT && cmd_data_i[6] |=>
      cml_fault_o && $stable(ot_action_reg[0]) && $stable(ot_action_reg[1]))
    else $error("unsupported external response was stored");

  ext_ot_flag_a: assert property (
    sample && ext_ot_i[0] |=> ##1 status_o.ext_ot[0] && status_o.temp_summary && alert_o)
    else $error("external overtemperature not flagged after sampling");

  ext_ut_flag_a: assert property (
    sample && ext_ut_i[1] |=> ##1 status_o.ext_ut[1] && status_o.temp_summary)
    else $error("external undertemperature not flagged after sampling");

endmodule

// *** logic/temp_fault_pkg.sv ***
// constants, field layouts and types for the temperature fault response block
// assumes a 125 MHz core clock and a byte-wide command port fed by the serial front end
package temp_fault_pkg;

  // command codes of the three action bytes and the fault clear command
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_EXT_OT = 8'h50;
  localparam logic [7:0] CMD_EXT_UT = 8'h54;
  localparam logic [7:0] CMD_INT_OT = 8'hd6;
  localparam logic [7:0] READ_NONE = 8'h00;

  // reset and fixed values of the action bytes
  localparam logic [7:0] EXT_ACTION_RESET = 8'hb8;
  localparam logic [7:0] INT_ACTION_VALUE = 8'hc0;

  // response and retry encodings
  localparam logic [1:0] RESP_CONTINUE = 2'h0;
  localparam logic [1:0] RESP_UNSUP = 2'h1;
  localparam logic [1:0] RESP_SHUTDOWN = 2'h2;
  localparam logic [1:0] RESP_WHILE = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // channel count and timing
  localparam int CH_COUNT = 2;
  localparam int CLK_HZ = 125000000;
  localparam int RESP_LIMIT_MS = 90;
  localparam int RESP_LIMIT_CYCLES = RESP_LIMIT_MS * (CLK_HZ / 1000);

  // action byte layout: response, retry, delay
  typedef struct packed {
    logic [1:0] resp;
    logic [2:0] retry;
    logic [2:0] delay;
  } action_t;

  // faults seen by one channel
  typedef struct packed {
    logic int_ot;
    logic ext_ot;
    logic ext_ut;
  } ch_fault_t;

  // sticky status bits shown to the host
  typedef struct packed {
    logic mfr_summary;
    logic temp_summary;
    logic int_ot;
    logic [1:0] ext_ot;
    logic [1:0] ext_ut;
  } fault_status_t;

  // channel shutdown states
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_LATCH_OFF = 2'b01,
    ST_RETRY_WAIT = 2'b10
  } ch_state_t;

endpackage

// *** logic/channel_fault_ctrl.sv ***
// per-channel output shutdown and restart control for temperature faults
// assumes fault levels are already qualified and the retry interval timer is outside
`timescale 1ns/1ps
module channel_fault_ctrl
  import temp_fault_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic run_cmd_i,
  input wire ch_fault_t faults_i,
  input wire action_t int_action_i,
  input wire action_t ot_action_i,
  input wire action_t ut_action_i,
  input wire logic retry_due_i,
  output logic output_en_o,
  output logic retry_req_o
);

  ch_state_t state_reg, state_next;
  logic out_en_reg, out_en_next;
  logic retry_req_reg, retry_req_next;
  logic shut_int, hold_int, shut_ot, shut_ut, latch_any, retry_all;

  // decode of the programmed reactions; delay field is never looked at
  always_comb begin
    shut_int = faults_i.int_ot && (int_action_i.resp == RESP_SHUTDOWN);
    hold_int = faults_i.int_ot && (int_action_i.resp == RESP_WHILE);
    shut_ot = faults_i.ext_ot && (ot_action_i.resp == RESP_SHUTDOWN);
    shut_ut = faults_i.ext_ut && (ut_action_i.resp == RESP_SHUTDOWN);
    latch_any = shut_int || shut_ot || shut_ut; // code 00 never shuts down
    // internal fault never retries external retries only on 111
    retry_all = !shut_int && (!shut_ot || ot_action_i.retry == RETRY_FOREVER) &&
                (!shut_ut || ut_action_i.retry == RETRY_FOREVER);
  end

  // next state and registered outputs
  always_comb begin
    state_next = state_reg;
    if (!run_cmd_i) begin
      state_next = ST_RUN; // commanded off releases a latched shutdown
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (latch_any) begin
            state_next = retry_all ? ST_RETRY_WAIT : ST_LATCH_OFF;
          end
        end
        ST_LATCH_OFF: begin
          state_next = ST_LATCH_OFF; // held off until commanded off
        end
        ST_RETRY_WAIT: begin
          if (latch_any && !retry_all) begin
            state_next = ST_LATCH_OFF; // another fault ends retrying
          end else if (retry_due_i) begin
            state_next = latch_any ? ST_RETRY_WAIT : ST_RUN;
          end
        end
        default: begin
          state_next = ST_RUN;
        end
      endcase
    end
    // output off at once on shutdown, and only while fault lasts for 11
    out_en_next = run_cmd_i && (state_next == ST_RUN) && !latch_any && !hold_int;
    retry_req_next = (state_next == ST_RETRY_WAIT);
  end

  // state registers
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_reg <= ST_RUN;
      out_en_reg <= 1'b0;
      retry_req_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      out_en_reg <= out_en_next;
      retry_req_reg <= retry_req_next;
    end
  end

  assign output_en_o = out_en_reg;
  assign retry_req_o = retry_req_reg;

endmodule

// *** testbench/host_port_model.sv ***
// host side model: issues reads and writes on the command port
// assumes the device answers a read at the taking edge and holds the answer for one cycle
`timescale 1ns/1ps
module host_port_model (
  input wire logic ref_clk_i,
  input wire logic read_valid_i,
  input wire logic [7:0] read_data_i,
  output logic cmd_write_o,
  output logic cmd_read_o,
  output logic [7:0] cmd_code_o,
  output logic cmd_page_o,
  output logic [7:0] cmd_data_o
);
  // idle port at time zero
  initial begin
    cmd_write_o = 1'b0;
    cmd_read_o = 1'b0;
    cmd_code_o = 8'h00;
    cmd_page_o = 1'b0;
    cmd_data_o = 8'h00;
  end

  // one write held across one rising edge; released code and data lines show no stale value
  task automatic write_cmd(input logic [7:0] code, input logic page, input logic [7:0] data);
    @(negedge ref_clk_i);
    cmd_code_o = code;
    cmd_page_o = page;
    cmd_data_o = data;
    cmd_write_o = 1'b1;
    @(negedge ref_clk_i);
    cmd_write_o = 1'b0;
    cmd_code_o = ~code;
    cmd_data_o = ~data;
  endtask

  // one read; the answer is looked for within a few cycles
  task automatic read_cmd(input logic [7:0] code, input logic page, output logic [7:0] data,
                          output logic ok);
    int n;
    ok = 1'b0;
    data = 8'h00;
    @(negedge ref_clk_i);
    cmd_code_o = code;
    cmd_page_o = page;
    cmd_read_o = 1'b1;
    @(negedge ref_clk_i);
    cmd_read_o = 1'b0;
    cmd_code_o = ~code;
    for (n = 0; n < 4 && !ok; n++) begin
      if (read_valid_i === 1'b1) begin
        ok = 1'b1;
        data = read_data_i;
      end else begin
        @(negedge ref_clk_i);
      end
    end
  endtask
endmodule

// *** testbench/temperature_fault_response_tb.sv ***
// testbench for the temperature fault response block
// assumes the host model drives the command port, all else driven here
`timescale 1ns/1ps
module temperature_fault_response_tb;
  import temp_fault_pkg::*;
  localparam int LIMIT = 16;
  logic ref_clk_i, reset_i, int_ot_i, adc_update_i;
  logic [1:0] ext_ot_i, ext_ut_i, channel_run_pin_i, operation_on_i, retry_due_i;
  logic cmd_write, cmd_read, cmd_page, read_valid, cml_fault, alert, ok;
  logic [7:0] cmd_code, cmd_data, read_data, rd;
  logic [1:0] output_en, retry_req;
  fault_status_t status;
  logic [7:0] bad [4] = '{8'h00, 8'h40, 8'hc8, 8'hf8};
  int mismatches = 0;
  int checked = 0;

  temp_fault_response #(.RESP_LIMIT(LIMIT)) dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .cmd_write_i(cmd_write), .cmd_read_i(cmd_read), .cmd_code_i(cmd_code),
    .cmd_page_i(cmd_page), .cmd_data_i(cmd_data), .int_ot_i(int_ot_i), .ext_ot_i(ext_ot_i),
    .ext_ut_i(ext_ut_i), .adc_update_i(adc_update_i), .channel_run_pin_i(channel_run_pin_i),
    .operation_on_i(operation_on_i), .retry_due_i(retry_due_i), .read_data_o(read_data),
    .read_valid_o(read_valid), .cml_fault_o(cml_fault), .status_o(status), .alert_o(alert),
    .output_en_o(output_en), .retry_req_o(retry_req));

  host_port_model host (.ref_clk_i(ref_clk_i), .read_valid_i(read_valid),
    .read_data_i(read_data), .cmd_write_o(cmd_write), .cmd_read_o(cmd_read),
    .cmd_code_o(cmd_code), .cmd_page_o(cmd_page), .cmd_data_o(cmd_data));

  // 125 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  // read one action byte and compare it
  task automatic rd_chk(input logic [7:0] code, input logic page, input logic [7:0] exp);
    host.read_cmd(code, page, rd, ok);
    if (!ok) begin
      mismatches++;
      final_report();
    end else begin
      check("action byte", rd, exp);
    end
  endtask

  // one conversion-done pulse
  task automatic adc_pulse();
    adc_update_i = 1'b1;
    cycles(1);
    adc_update_i = 1'b0;
    cycles(3);
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    mismatches++;
    final_report();
  end

  // main sequence
  initial begin
    reset_i = 1'b1;
    int_ot_i = 1'b0;
    adc_update_i = 1'b0;
    ext_ot_i = 2'h0;
    ext_ut_i = 2'h0;
    channel_run_pin_i = 2'h0;
    operation_on_i = 2'h0;
    retry_due_i = 2'h0;
    cycles(16);
    reset_i = 1'b0;
    check("status", {1'b0, status}, 8'h00);
    rd_chk(CMD_EXT_OT, 1'b0, 8'hb8);
    rd_chk(CMD_EXT_OT, 1'b1, 8'hb8);
    rd_chk(CMD_EXT_UT, 1'b0, 8'hb8);
    rd_chk(CMD_EXT_UT, 1'b1, 8'hb8);
    rd_chk(CMD_INT_OT, 1'b1, 8'hc0);
    host.write_cmd(CMD_EXT_OT, 1'b1, 8'hbf);
    rd_chk(CMD_EXT_OT, 1'b1, 8'hbf);
    rd_chk(CMD_EXT_OT, 1'b0, 8'hb8);
    host.write_cmd(CMD_EXT_UT, 1'b0, 8'h00);
    rd_chk(CMD_EXT_UT, 1'b0, 8'h00);
    check("cml", {7'h00, cml_fault}, 8'h00);
    host.write_cmd(CMD_EXT_OT, 1'b0, 8'h40);
    check("cml", {7'h00, cml_fault}, 8'h01);
    rd_chk(CMD_EXT_OT, 1'b0, 8'hb8);
    // each of four unsupported internal codes (00, 40, c8, f8) raises cml, cleared between tries
    for (int i = 0; i < 4; i++) begin
      host.write_cmd(CMD_CLEAR_FAULTS, 1'b0, 8'h00);
      check("cml clear", {7'h00, cml_fault}, 8'h00);
      host.write_cmd(CMD_INT_OT, 1'b0, bad[i]);
      check("cml int", {7'h00, cml_fault}, 8'h01);
    end
    host.write_cmd(CMD_CLEAR_FAULTS, 1'b0, 8'h00);
    host.write_cmd(CMD_INT_OT, 1'b1, 8'hc7);
    check("cml delay", {7'h00, cml_fault}, 8'h00);
    rd_chk(CMD_INT_OT, 1'b0, 8'hc0);
    host.write_cmd(CMD_EXT_OT, 1'b0, 8'h00);
    // both channels running, then internal overtemperature
    channel_run_pin_i = 2'h3;
    operation_on_i = 2'h3;
    cycles(3);
    check("output_en", {6'h00, output_en}, 8'h03);
    int_ot_i = 1'b1;
    cycles(2);
    check("status", {1'b0, status}, 8'h50);
    check("alert", {7'h00, alert}, 8'h01);
    check("output_en", {6'h00, output_en}, 8'h00);
    int_ot_i = 1'b0;
    cycles(3);
    check("output_en", {6'h00, output_en}, 8'h03);
    check("status", {1'b0, status}, 8'h50);
    host.write_cmd(CMD_CLEAR_FAULTS, 1'b0, 8'h00);
    check("status", {1'b0, status}, 8'h00);
    check("alert", {7'h00, alert}, 8'h00);
    channel_run_pin_i = 2'h0;
    cycles(2);
    check("output_en", {6'h00, output_en}, 8'h00);
    channel_run_pin_i = 2'h3;
    cycles(3);
    check("output_en", {6'h00, output_en}, 8'h03);
    // external overtemperature on channel 0 with flag-only response
    ext_ot_i = 2'h1;
    adc_pulse();
    check("status", {1'b0, status}, 8'h24);
    check("alert", {7'h00, alert}, 8'h01);
    check("output_en", {6'h00, output_en}, 8'h03);
    ext_ot_i = 2'h0;
    adc_pulse();
    host.write_cmd(CMD_CLEAR_FAULTS, 1'b0, 8'h00);
    // external undertemperature on channel 1, default shutdown with endless retry
    ext_ut_i = 2'h2;
    adc_pulse();
    check("status", {1'b0, status}, 8'h22);
    check("output_en", {6'h00, output_en}, 8'h01);
    check("retry_req", {6'h00, retry_req}, 8'h02);
    ext_ut_i = 2'h0;
    adc_pulse();
    check("output_en", {6'h00, output_en}, 8'h01);
    retry_due_i = 2'h2;
    cycles(1);
    retry_due_i = 2'h0;
    cycles(2);
    check("output_en", {6'h00, output_en}, 8'h03);
    // external fault found by the sample counter alone, no conversion pulse
    host.write_cmd(CMD_CLEAR_FAULTS, 1'b0, 8'h00);
    ext_ot_i = 2'h2;
    for (int n = 0; n < LIMIT + 4 && status.ext_ot[1] !== 1'b1; n++) begin
      cycles(1);
    end
    check("ext_ot seen", {7'h00, status.ext_ot[1]}, 8'h01);
    cycles(3);
    check("output_en", {6'h00, output_en}, 8'h01);
    final_report();
  end
endmodule
